/* File: inc/tec_defs.svh */
`ifndef TEC_DEFS_SVH
`define TEC_DEFS_SVH
// register byte offsets
`define TEC_OFF_CTRL 8'h00
`define TEC_OFF_CFG 8'h04
`define TEC_OFF_STAT 8'h08
`define TEC_OFF_CNT0 8'h10
`define TEC_CNT_MASK 8'hf3
// control word: four bits each, one per channel, except the single factory bit
`define TEC_CTRL_START 0
`define TEC_CTRL_STOP 4
`define TEC_CTRL_CLEAR 8
`define TEC_CTRL_PONSTOP 12
`define TEC_CTRL_PONSTART 16
`define TEC_CTRL_STDCFG 20
`define TEC_CTRL_FACTORY 24
// configuration and status fields
`define TEC_CFG_EDGE 0
`define TEC_CFG_MODE 4
`define TEC_STAT_RUN 0
`define TEC_STAT_PON 4
`define TEC_STAT_LVL 8
// reset values
`define TEC_EDGE_RST 4'h0
`define TEC_MODE_RST 4'h0
`define TEC_PON_RST 4'h0
`endif

/* File: inc/tec_pkg.sv */
package tec_pkg;
  typedef logic [31:0] tec_word_t;
  typedef enum logic [1:0] {TEC_OKAY = 2'b00, TEC_SLVERR = 2'b10} tec_resp_e;
endpackage

/* File: inc/tec_chan_if.sv */
`timescale 1ns/1ps
interface tec_chan_if #(parameter int W = 32);
  logic start_now;
  logic stop_now;
  logic clear_now;
  logic rd_clear;
  logic falling_sel;
  logic edge_in;
  logic running;
  logic [W-1:0] count;
  modport ctrl (output start_now, stop_now, clear_now, rd_clear, falling_sel, edge_in, input running, count);
  modport chan (input start_now, stop_now, clear_now, rd_clear, falling_sel, edge_in, output running, count);
endinterface

/* File: design/tec_chan.sv */
`timescale 1ns/1ps
module tec_chan
  import tec_pkg::*;
#(
  parameter int W = 32
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls and state
  tec_chan_if.chan cif
);

  logic samp_q;
  logic prev_q;
  logic run_q;
  logic [W-1:0] cnt_q;
  logic edge_hit;
  logic inc;
  logic zero;

  // sample and keep the prior level for edge compare
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      samp_q <= cif.edge_in;
      prev_q <= samp_q;
    end
  end

  // one hit per transition, polarity per channel
  assign edge_hit = cif.falling_sel ? (prev_q & ~samp_q) : (~prev_q & samp_q);
  assign inc = edge_hit & run_q; // a stopped channel ignores edges
  assign zero = cif.clear_now | cif.rd_clear;

  // run flag: stop wins if both arrive together
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      run_q <= 1'b0;
    else if (cif.stop_now)
      run_q <= 1'b0;
    else if (cif.start_now)
      run_q <= 1'b1;
  end

  // count: a clear does not swallow an edge in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (zero)
      cnt_q <= inc ? W'(1) : '0;
    else if (inc)
      cnt_q <= cnt_q + W'(1); // natural wrap to zero
  end

  assign cif.running = run_q;
  assign cif.count = cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_wrap;
    inc && !zero && (&cnt_q) |=> cnt_q == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");
  property p_hold;
    !run_q && !zero |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped count changed");
  property p_stop;
    cif.stop_now |=> !run_q ##1 (!run_q || $past(cif.start_now));
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt channel");
  property p_start;
    rst_n && cif.start_now && !cif.stop_now |=> run_q;
  endproperty
  a_start: assert property (p_start) else $error("start did not enable channel");
  property p_edge;
    run_q && !zero && edge_hit |=> cnt_q == $past(cnt_q) + W'(1);
  endproperty
  a_edge: assert property (p_edge) else $error("qualifying edge not counted");
  property p_once;
    samp_q == prev_q && !zero |=> $stable(cnt_q);
  endproperty
  a_once: assert property (p_once) else $error("count moved without a transition");

endmodule // tec_chan

/* File: design/tec_top.sv */
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "tec_defs.svh"
// Operation
// - each channel holds an unsigned 32-bit count that wraps from all ones to zero on one more edge.
// - in read-and-clear mode a count read returns the value and zeroes it in the same action.
// - each channel counts rising or falling transitions of its input as its edge select says.
// - the standard count configuration forces a channel to rising-edge counting.
// - factory reset sets every edge select to rising; preset or card reset leaves it alone.
// - the edge select of every channel reads back as falling or rising.
// - a start-now request enables counting at once.
// - a channel whose power-on start flag is set begins counting as soon as power-on completes.
// - the power-on start flag reads back as 1 when set and 0 when clear.
// - the four counters are the local channels 05 to 08 of a slot, here words 0 to 3.
// - reading several counts returns one value per channel in the order requested.
// - a stop-now request halts counting at once so later edges leave the count alone.
// - read mode selects plain read or read-and-clear; factory reset selects plain read.
// - a power-on stop request clears the power-on start flag.
// - factory reset and clear-now zero the counts; preset or card reset leaves them alone.
module tec_top
  import tec_pkg::*;
#(
  parameter int CW = 32,
  parameter int NCH = 4,
  parameter logic [3:0] PON_INIT = `TEC_PON_RST
)
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // thresholded event inputs, one per channel
  input wire logic [NCH-1:0] EDGE_IN,
  // axi4-lite write address and data
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  // byte enables widened to a bit mask
  function automatic tec_word_t strb_mask(input logic [3:0] s);
    tec_word_t m;
    m = '0;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = {8{s[b]}};
    return m;
  endfunction

  // count word window: offsets 0x10..0x1c, aligned
  function automatic logic cnt_hit(input logic [7:0] a);
    return (a & `TEC_CNT_MASK) == `TEC_OFF_CNT0;
  endfunction

  // ************************************************************
  // bus slave state
  // ************************************************************
  logic aw_have_q;
  logic w_have_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [7:0] awaddr_q;
  tec_word_t wdata_q;
  logic [3:0] wstrb_q;
  tec_resp_e bresp_q;
  tec_resp_e rresp_q;
  tec_word_t rdata_q;
  logic do_write;
  logic ar_hs;
  logic wr_ctrl;
  logic wr_cfg;
  tec_word_t wmask;
  tec_word_t ctrl_bits;
  tec_word_t cfg_bits;
  logic factory;
  logic [1:0] ar_idx;
  tec_word_t rd_mux;
  logic rd_err;
  // channel settings
  logic [NCH-1:0] edge_sel_q;
  logic [NCH-1:0] rmode_q;
  logic [NCH-1:0] pon_q;
  logic pon_done_q;
  logic pon_fire;
  logic [NCH-1:0] start_v;
  logic [NCH-1:0] stop_v;
  logic [NCH-1:0] clear_v;
  logic [NCH-1:0] pstop_v;
  logic [NCH-1:0] pstart_v;
  logic [NCH-1:0] std_v;
  logic [NCH-1:0] rdclr_v;
  logic [NCH-1:0] run_v;
  logic [NCH-1:0] low_v;
  logic [CW-1:0] cnt_arr [NCH];
  logic [CW-1:0] cnt_sel;
  // ************************************************************
  // write path
  // ************************************************************
  // a write needs both address and data; either may come first
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wmask = strb_mask(wstrb_q);
  assign wr_ctrl = do_write && (awaddr_q == `TEC_OFF_CTRL);
  assign wr_cfg = do_write && (awaddr_q == `TEC_OFF_CFG);
  assign ctrl_bits = wr_ctrl ? (wdata_q & wmask) : '0;
  assign cfg_bits = wdata_q & wmask;
  // per-channel command pulses from the control word
  assign start_v = ctrl_bits[`TEC_CTRL_START +: NCH];
  assign stop_v = ctrl_bits[`TEC_CTRL_STOP +: NCH];
  assign pstop_v = ctrl_bits[`TEC_CTRL_PONSTOP +: NCH];
  assign pstart_v = ctrl_bits[`TEC_CTRL_PONSTART +: NCH];
  assign std_v = ctrl_bits[`TEC_CTRL_STDCFG +: NCH];
  assign factory = ctrl_bits[`TEC_CTRL_FACTORY];
  assign clear_v = ctrl_bits[`TEC_CTRL_CLEAR +: NCH] | {NCH{factory}};
  // address and data holding registers
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      else if (do_write)
        aw_have_q <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      else if (do_write)
        w_have_q <= 1'b0;
    end
  end
  // write response; read-only and unmapped words answer slverr
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= TEC_OKAY;
    end
    else if (do_write)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_ctrl || wr_cfg) ? TEC_OKAY : TEC_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_q <= 1'b0;
  end
  // holding registers full means the channel stalls
  assign S_AXI_AWREADY = ~aw_have_q;
  assign S_AXI_WREADY = ~w_have_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // ************************************************************
  // settings registers
  // ************************************************************
  // edge select; factory and standard config both force rising
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      edge_sel_q <= `TEC_EDGE_RST;
    else if (factory)
      edge_sel_q <= `TEC_EDGE_RST;
    else if (wr_cfg)
      edge_sel_q <= (edge_sel_q & ~wmask[`TEC_CFG_EDGE +: NCH]) | cfg_bits[`TEC_CFG_EDGE +: NCH];
    else
      edge_sel_q <= edge_sel_q & ~std_v;
  end

  // read mode; standard config also returns to plain read
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      rmode_q <= `TEC_MODE_RST;
    else if (factory)
      rmode_q <= `TEC_MODE_RST;
    else if (wr_cfg)
      rmode_q <= (rmode_q & ~wmask[`TEC_CFG_MODE +: NCH]) | cfg_bits[`TEC_CFG_MODE +: NCH];
    else
      rmode_q <= rmode_q & ~std_v;
  end

  // power-on start flags; a set in the same write beats the stop
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      pon_q <= PON_INIT;
    else
      pon_q <= (pon_q & ~pstop_v) | pstart_v;
  end

  // first cycle after reset release marks power-on complete
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      pon_done_q <= 1'b0;
    else
      pon_done_q <= 1'b1;
  end
  assign pon_fire = ~pon_done_q;

  // ************************************************************
  // counting channels, local 05..08 map to words 0..3
  // ************************************************************
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      tec_chan_if #(.W(CW)) cif ();
      assign cif.start_now = start_v[i] | (pon_fire & pon_q[i]);
      assign cif.stop_now = stop_v[i];
      assign cif.clear_now = clear_v[i];
      assign cif.rd_clear = rdclr_v[i];
      assign cif.falling_sel = edge_sel_q[i];
      assign cif.edge_in = EDGE_IN[i];
      assign run_v[i] = cif.running;
      assign cnt_arr[i] = cif.count;
      assign low_v[i] = (cnt_arr[i] <= CW'(1)); // cleared, or one edge taken during the clear
      // clear only the word being read, and only in read-and-clear mode
      assign rdclr_v[i] = ar_hs && cnt_hit(S_AXI_ARADDR) && (ar_idx == 2'(i)) && rmode_q[i];
      tec_chan #(.W(CW)) u_chan (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .cif(cif)
      );
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  assign ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  assign ar_idx = S_AXI_ARADDR[3:2];
  assign cnt_sel = cnt_arr[ar_idx];
  // read data selection; control word reads as zero
  always_comb
  begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (S_AXI_ARADDR == `TEC_OFF_CTRL)
      rd_mux = '0;
    else if (S_AXI_ARADDR == `TEC_OFF_CFG)
    begin
      rd_mux[`TEC_CFG_EDGE +: NCH] = edge_sel_q; // 1 = falling
      rd_mux[`TEC_CFG_MODE +: NCH] = rmode_q;
    end
    else if (S_AXI_ARADDR == `TEC_OFF_STAT)
    begin
      rd_mux[`TEC_STAT_RUN +: NCH] = run_v;
      rd_mux[`TEC_STAT_PON +: NCH] = pon_q;
      rd_mux[`TEC_STAT_LVL +: NCH] = EDGE_IN;
    end
    else if (cnt_hit(S_AXI_ARADDR))
      rd_mux = 32'(cnt_sel);
    else
      rd_err = 1'b1;
  end

  // value captured at the same edge that clears the count
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= TEC_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_err ? TEC_SLVERR : TEC_OKAY;
    end
    else if (S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end
  // one read in flight; a new address waits for the answer to drain
  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  sequence s_cnt_read;
    ar_hs && cnt_hit(S_AXI_ARADDR);
  endsequence
  sequence s_clr_read;
    s_cnt_read ##0 rmode_q[ar_idx];
  endsequence
  property p_rd_order;
    s_cnt_read |=> S_AXI_RVALID && S_AXI_RDATA == 32'($past(cnt_sel));
  endproperty
  a_rd_order: assert property (p_rd_order) else $error("count read returned wrong value");
  property p_rd_clear;
    s_clr_read |=> cnt_arr[$past(ar_idx)] <= CW'(1);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read-and-clear left count");
  property p_factory;
    factory |=> edge_sel_q == '0 && rmode_q == '0;
  endproperty
  a_factory: assert property (p_factory) else $error("factory reset left settings");
  property p_std;
    |std_v |=> (edge_sel_q & $past(std_v)) == '0;
  endproperty
  a_std: assert property (p_std) else $error("standard config kept falling edge");
  property p_pon_stop;
    |pstop_v |=> (pon_q & $past(pstop_v & ~pstart_v)) == '0;
  endproperty
  a_pon_stop: assert property (p_pon_stop) else $error("power-on stop kept flag");
  property p_pon_start;
    RSTN && pon_fire |=> (run_v & $past(pon_q & ~stop_v)) == $past(pon_q & ~stop_v);
  endproperty
  a_pon_start: assert property (p_pon_start) else $error("power-on start not taken");
  property p_cfg_read;
    ar_hs && S_AXI_ARADDR == `TEC_OFF_CFG |=> S_AXI_RDATA[`TEC_CFG_EDGE +: NCH] == $past(edge_sel_q);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("edge select readback wrong");
  property p_pon_read;
    ar_hs && S_AXI_ARADDR == `TEC_OFF_STAT |=> S_AXI_RDATA[`TEC_STAT_PON +: NCH] == $past(pon_q);
  endproperty
  a_pon_read: assert property (p_pon_read) else $error("power-on flag readback wrong");
  property p_clear;
    |clear_v |=> (low_v & $past(clear_v)) == $past(clear_v);
  endproperty
  a_clear: assert property (p_clear) else $error("clear-now left count");
  property p_bresp;
    do_write |=> S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered");

endmodule // tec_top

/* File: tb/tec_evt_src.sv */
`timescale 1ns/1ps
// ****************************************
// thresholded event source model
// ****************************************
module tec_evt_src
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // burst request
  input wire logic go,
  input wire logic [3:0] mask,
  input wire logic [15:0] n,
  input wire logic [3:0] gap,
  output logic busy,
  // comparator outputs
  output logic [3:0] edge_out
);
  logic [15:0] left_q;
  logic [3:0] wait_q;
  logic [3:0] gap_q;
  logic [3:0] mask_q;
  // toggle masked lines n times, each level held gap+1 cycles so slow and fast pulses both occur
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edge_out <= 4'h0;
      left_q <= 16'h0000;
      wait_q <= 4'h0;
      gap_q <= 4'h0;
      mask_q <= 4'h0;
    end
    else if (go && left_q == 16'h0000)
    begin
      left_q <= n;
      wait_q <= gap;
      gap_q <= gap;
      mask_q <= mask;
    end
    else if (left_q != 16'h0000)
    begin
      if (wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else
      begin
        edge_out <= edge_out ^ mask_q;
        left_q <= left_q - 16'h0001;
        wait_q <= gap_q;
      end
    end
  end
  assign busy = (left_q != 16'h0000);
endmodule // tec_evt_src

/* File: tb/test_tec_top.sv */
`timescale 1ns/1ps
`include "tec_defs.svh"
module test_tec_top
  import tec_pkg::*;
;
  // short counters so the wrap is reachable in a short run
  localparam int CNT_W = 8;
  localparam logic [3:0] PON = 4'h9;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, go, busy;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] mask, gap, edge_w;
  logic [15:0] n;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [3:0] run_s, pon_s, edge_s, mode_s, lvl_s;
  logic [CNT_W-1:0] cnt_s[4];
  int bad_count, n_checks;
  // ****************************************
  // clock, design and event source
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tec_top #(.CW(CNT_W), .PON_INIT(PON)) tec_top_inst (.SYS_CLK(clk), .RSTN(rstn), .EDGE_IN(edge_w),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  tec_evt_src tec_evt_src_inst (.clk(clk), .rst_n(rstn), .go(go), .mask(mask), .n(n), .gap(gap),
    .busy(busy), .edge_out(edge_w));
  // ****************************************
  // verdict and checks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // monitor takes the oldest note whenever a response is handed over
  always @(posedge clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      if (rq.size() == 0) bad_count++; else cmp({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1)
      if (bq.size() == 0) bad_count++; else cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    test_done();
  end
  // ****************************************
  // reference model of the channel bank
  // ****************************************
  task automatic apply(input logic [7:0] a, input logic [31:0] d);
    if (a == `TEC_OFF_CFG)
    begin
      edge_s = d[3:0];
      mode_s = d[7:4];
    end
    if (a == `TEC_OFF_CTRL)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (d[8+i] || d[24]) cnt_s[i] = '0;
        if (d[20+i] || d[24]) {edge_s[i], mode_s[i]} = 2'b00;
      end
      run_s = (run_s | d[3:0]) & ~d[7:4]; // stop wins over start
      pon_s = (pon_s & ~d[15:12]) | d[19:16];
    end
  endtask
  task automatic toggle(input logic [3:0] m, input int k);
    for (int j = 0; j < k; j++)
      for (int i = 0; i < 4; i++)
        if (m[i])
        begin
          if (run_s[i] && (edge_s[i] ? lvl_s[i] : !lvl_s[i])) cnt_s[i]++;
          lvl_s[i] = !lvl_s[i];
        end
  endtask
  // ****************************************
  // bus and stimulus tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    bq.push_back((a == `TEC_OFF_CTRL || a == `TEC_OFF_CFG) ? TEC_OKAY : TEC_SLVERR);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 200);
    bready <= 1'b0;
    if (t >= 200) bad_count++;
    if (a == `TEC_OFF_CTRL || a == `TEC_OFF_CFG) apply(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    logic [33:0] e;
    @(posedge clk);
    e = {TEC_SLVERR, 32'h0};
    if (a == `TEC_OFF_CTRL) e = {TEC_OKAY, 32'h0};
    if (a == `TEC_OFF_CFG) e = {TEC_OKAY, 24'h0, mode_s, edge_s};
    if (a == `TEC_OFF_STAT) e = {TEC_OKAY, 20'h0, lvl_s, pon_s, run_s};
    if ((a & `TEC_CNT_MASK) == `TEC_OFF_CNT0)
    begin
      e = {TEC_OKAY, 32'(cnt_s[a[3:2]])};
      if (mode_s[a[3:2]]) cnt_s[a[3:2]] = '0; // read and clear in one action
    end
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 200);
    rready <= 1'b0;
    if (t >= 200) bad_count++;
  endtask
  task automatic pulses(input logic [3:0] m, input int k, input logic [3:0] g);
    int t;
    @(posedge clk);
    mask <= m;
    n <= 16'(k);
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end while (busy !== 1'b0 && t < 20000);
    if (t >= 20000) bad_count++;
    repeat (3) @(posedge clk); // sample and compare stages settle
    toggle(m, k);
  endtask
  task automatic check_all();
    rd(`TEC_OFF_CFG);
    rd(`TEC_OFF_STAT);
    for (int i = 3; i >= 0; i--) rd(8'(`TEC_OFF_CNT0 + 4 * i));
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    {run_s, pon_s, edge_s, mode_s, lvl_s} = {PON, PON, 12'h0};
    for (int i = 0; i < 4; i++) cnt_s[i] = '0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h0;
    {awaddr, araddr, wdata, mask, gap, n} = '0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(32'hd977c97e));
    do_reset();
    check_all();
    pulses(4'hf, 6, 4'h2);
    check_all();
    rd(8'h20);
    rd(`TEC_OFF_CTRL);
    wr(`TEC_OFF_STAT, 32'hffff_ffff);
    wr(8'h14, 32'h0000_0001);
    wr(`TEC_OFF_CTRL, 32'h0000_000f);
    for (int k = 0; k < 6; k++)
    begin
      if (k == 3) wr(`TEC_OFF_CFG, $urandom_range(0, 255) | 32'h30);
      pulses(4'($urandom_range(1, 15)), $urandom_range(1, 9), 4'($urandom_range(0, 4)));
      check_all();
      check_all();
    end
    wr(`TEC_OFF_CTRL, 32'h0000_0035);
    pulses(4'hf, 5, 4'h1);
    check_all();
    wr(`TEC_OFF_CFG, 32'h0000_000f);
    wr(`TEC_OFF_CTRL, 32'h0000_020f);
    pulses(4'h3, 4, 4'h0);
    wr(`TEC_OFF_CTRL, 32'h00c0_0000);
    check_all();
    wr(`TEC_OFF_CTRL, 32'h0002_9000);
    rd(`TEC_OFF_STAT);
    wr(`TEC_OFF_CTRL, 32'h0001_1000);
    rd(`TEC_OFF_STAT);
    wr(`TEC_OFF_CFG, 32'h0000_0000);
    pulses(4'h2, 2 * 258 + 1, 4'h1);
    check_all();
    wr(`TEC_OFF_CFG, 32'h0000_00a5);
    wr(`TEC_OFF_CTRL, 32'h0100_0000);
    check_all();
    do_reset();
    check_all();
    test_done();
  end
endmodule // test_tec_top
